// ---- dv/sse_exec_monitor.sv ----
`timescale 1ns/1ps
// ------------------------------
// port checker for the exec slice
// ------------------------------
module sse_exec_monitor (
  input logic        clk,
  input logic        reset,
  input logic        bus_rd,
  input logic [15:0] bus_rdata,
  input logic        instr_valid,
  input logic [7:0]  instr_byte,
  input logic        instr_ready,
  input logic        mem_rd,
  input logic        mem_wr,
  input logic [15:0] mem_addr,
  input logic [7:0]  mem_wdata,
  input logic [7:0]  mem_rdata,
  input logic        op_done
);
  logic [7:0] last_op;

  // last byte taken is the op byte, since fetch stalls during the access
  always @(posedge clk) begin
    if (reset)
      last_op <= 8'h00;
    else if (instr_valid && instr_ready)
      last_op <= instr_byte;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_set_mem_bit: assert property (mem_wr && last_op[7:6] == 2'b11
    |-> mem_wdata == ($past(mem_rdata) | (8'h01 << last_op[5:3]))) else $error("set bit wrong");
  a_shl_mem_data: assert property (mem_wr && last_op[7:3] == 5'h04
    |-> mem_wdata == {$past(mem_rdata[6:0]), 1'b0}) else $error("left shift wrong");
  a_shr_mem_data: assert property (mem_wr && last_op[7:3] == 5'h05
    |-> mem_wdata == {$past(mem_rdata[7]), $past(mem_rdata[7:1])}) else $error("right shift wrong");
  a_rmw_write_back: assert property (mem_rd && (last_op[7:6] == 2'b11 || last_op[7:4] == 4'h2)
    |-> ##2 mem_wr && mem_addr == $past(mem_addr, 2)) else $error("write back missing");
  a_done_with_wr: assert property (mem_wr |-> op_done) else $error("done not with write");
  a_fetch_stall: assert property (mem_rd |-> !instr_ready ##1 !instr_ready)
    else $error("fetch during access");
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside slot");
  a_read_pulse: assert property (mem_rd |=> !mem_rd) else $error("read not a pulse");

  c_set_mem: cover property (mem_wr && last_op[7:6] == 2'b11);
  c_reg_done: cover property (op_done && !mem_wr);
  c_bus_read: cover property ($past(bus_rd) && bus_rdata != 16'h0000);
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`include "sse_map.vh"
module testbench;
  logic        clk, reset, bus_wr, bus_rd, instr_valid, instr_ready, mem_rd, mem_wr, op_done;
  logic [3:0]  bus_addr;
  logic [15:0] bus_wdata, bus_rdata, mem_addr, seed, ea, wa;
  logic [7:0]  instr_byte, mem_wdata, mem_rdata, mv, wd;
  logic [15:0] r [0:7];
  int          n_fail, compares;

  sse_exec u_sse_exec (.clk, .reset, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .instr_valid, .instr_byte, .instr_ready, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
    .mem_rdata, .op_done);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // memory answers the cycle after a read; otherwise the data lines wander
  always @(posedge clk) begin
    mem_rdata <= mem_rd ? mv : ~mem_rdata;
    if (mem_wr) begin
      wa <= mem_addr;
      wd <= mem_wdata;
    end
  end

  // ----------------
  // helpers
  // ----------------
  function automatic [15:0] lfsr(input [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic [7:0] get8(input [2:0] c);
    return c == 3'h7 ? r[6][15:8] : (c[0] ? r[c[2:1]][7:0] : r[c[2:1]][15:8]);
  endfunction
  task automatic set8(input [2:0] c, input [7:0] v);
    if (c == 3'h7) r[6][15:8] = v;
    else if (c[0]) r[c[2:1]][7:0] = v;
    else r[c[2:1]][15:8] = v;
  endtask
  task automatic chk(input string nm, input [15:0] e, input [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bw(input [3:0] a, input [15:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask
  // read data stand only in the cycle before the second edge
  task automatic rd_all(input int n, input [7:0] fm);
    for (int a = 0; a < n; a++) begin
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(posedge clk);
      chk("bus_rdata", a > 6 ? 16'h0000 : r[a] & (a == 6 ? {8'hFF, fm} : 16'hFFFF),
        bus_rdata & (a == 6 ? {8'hFF, fm} : 16'hFFFF));
    end
  endtask
  task automatic send(input [7:0] b);
    instr_valid <= 1'b1;
    instr_byte <= b;
    do @(posedge clk); while (instr_ready !== 1'b1);
  endtask
  // lat is the number of edges from the last byte taken to the done pulse
  task automatic finish_op(input int lat);
    int w;
    instr_valid <= 1'b0;
    for (w = 0; w < 8 && op_done !== 1'b1; w++) @(posedge clk);
    chk("op_done", 16'h0001, {15'h0, op_done});
    chk("op_latency", lat[15:0], w[15:0]);
    @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------
  // main sequence
  // ----------------
  initial begin
    int i, kind, psel, form;
    logic [2:0] rc, b;
    logic [7:0] op, v, res, fm, d;
    logic [16:0] d17;
    logic [12:0] d13;
    {bus_wr, bus_rd, instr_valid, bus_addr, bus_wdata, instr_byte, mem_rdata, mv} = '0;
    n_fail = 0;
    compares = 0;
    seed = 16'h0005;
    for (i = 0; i < 8; i++) r[i] = 16'h0000;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_all(16, 8'hFF);
    bw(4'h7, 16'hFFFF);
    bw(4'hB, 16'hFFFF);
    // unknown bytes are swallowed with no result; the next opcode must still run
    send(8'h00);
    send(`SSE_PFX_ED);
    send(8'h00);
    send(`SSE_OP_SETC);
    r[6][7:0] = 8'h01;
    finish_op(1);
    rd_all(8, 8'hFF);
    for (i = 0; i < 80; i++) begin
      for (int k = 0; k < 7; k++) begin
        seed = lfsr(seed);
        r[k] = seed;
        bw(k, seed);
      end
      mv = seed[15:8];
      d = seed[7:0];
      kind = i / 8 % 5;
      rc = i % 8;
      b = (i / 8 + i) % 8;
      psel = i % 4;
      form = (rc == 3'h6 && i >= 40) ? 1 + (i / 8) % 2 : 0;
      fm = 8'hFF;
      if (kind == 0) begin
        send(`SSE_OP_SETC);
        r[6][7:0] = (r[6][7:0] | 8'h01) & 8'hED;
        finish_op(1);
      end else if (kind == 1) begin
        send(`SSE_PFX_ED);
        send({2'b01, psel[1:0], 4'b0010});
        d17 = {1'b0, r[2]} - r[psel] - r[6][0];
        d13 = {1'b0, r[2][11:0]} - r[psel][11:0] - r[6][0];
        r[6][7:0] = {d17[15], d17[15:0] == 16'h0, 1'b0, d13[12], 1'b0,
          r[2][15] != r[psel][15] && d17[15] != r[2][15], 1'b1, d17[16]};
        r[2] = d17[15:0];
        fm = 8'hD7;
        finish_op(1);
      end else begin
        op = kind == 2 ? {2'b11, b, rc} : {4'b0010, kind == 4, rc};
        if (form != 0) begin
          send(form == 1 ? `SSE_PFX_XIDX : `SSE_PFX_YIDX);
          send(`SSE_PFX_CB);
          send(d);
        end else
          send(`SSE_PFX_CB);
        send(op);
        ea = form != 0 ? r[3 + form] + {{8{d[7]}}, d} : r[2];
        v = (rc == 3'h6 || form != 0) ? mv : get8(rc);
        res = kind == 2 ? v | (8'h01 << b) : (kind == 3 ? {v[6:0], 1'b0} : {v[7], v[7:1]});
        if (kind != 2) begin
          r[6][7:0] = {res[7], res == 8'h00, 3'b000, ~^res, 1'b0, kind == 3 ? v[7] : v[0]};
          fm = 8'hD7;
        end
        finish_op((rc == 3'h6 || form != 0) ? 3 : 1);
        if (rc == 3'h6 || form != 0) begin
          chk("mem_addr", ea, wa);
          chk("mem_wdata", {8'h00, res}, {8'h00, wd});
        end else
          set8(rc, res);
      end
      rd_all(8, fm);
    end
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
endmodule

bind sse_exec sse_exec_monitor u_sse_exec_monitor (.clk, .reset, .bus_rd, .bus_rdata,
  .instr_valid, .instr_byte, .instr_ready, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
  .mem_rdata, .op_done);

// ---- src/sse_exec.v ----
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "sse_map.vh"

module sse_exec (
  input  wire        clk,
  input  wire        reset,
  input  wire [3:0]  bus_addr,
  input  wire [15:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [15:0] bus_rdata,
  input  wire        instr_valid,
  input  wire [7:0]  instr_byte,
  output reg         instr_ready,
  output reg         mem_rd,
  output reg         mem_wr,
  output reg  [15:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata,
  output reg         op_done
);

  // ----------------------------------------------------------------
  // states, one-hot
  // ----------------------------------------------------------------
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_ED   = 8'h02;
  localparam [7:0] S_CB   = 8'h04;
  localparam [7:0] S_IXP  = 8'h08;
  localparam [7:0] S_DISP = 8'h10;
  localparam [7:0] S_XOP  = 8'h20;
  localparam [7:0] S_MRD  = 8'h40;
  localparam [7:0] S_MWB  = 8'h80;

  reg [7:0]  state;
  reg [7:0]  next_state;
  reg [7:0]  gpr [0:7];     // slot 6 holds the flag byte, code 110 is memory
  reg [15:0] stk_reg;
  reg [15:0] xidx_reg;
  reg [15:0] yidx_reg;
  reg        use_yidx;
  reg [7:0]  disp;
  reg [7:0]  op_byte;

  wire       take = instr_valid & instr_ready;
  wire [7:0] flags = gpr[`SSE_CODE_F];
  wire [15:0] ptr_val = {gpr[`SSE_CODE_H], gpr[`SSE_CODE_L]};
  wire [15:0] idx_val = use_yidx ? yidx_reg : xidx_reg;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // pair_select_field decode, used only by the subtract source select
  function [15:0] pair_val;
    input [1:0]  sel;
    input [15:0] w_first;
    input [15:0] w_second;
    input [15:0] w_ptr;
    input [15:0] w_stk;
    begin
      case (sel)
        `SSE_PAIR_FIRST:  pair_val = w_first;
        `SSE_PAIR_SECOND: pair_val = w_second;
        `SSE_PAIR_PTR:    pair_val = w_ptr;
        default:          pair_val = w_stk;
      endcase
    end
  endfunction

  // bit-operation result: {handled, new flags, new byte}
  function [16:0] cb_result;
    input [7:0] op;
    input [7:0] val;
    input [7:0] f;
    reg   [7:0] res;
    reg   [7:0] nf;
    reg         hit;
    begin
      res = val;
      nf  = f;
      hit = 1'b0;
      if (op[7:6] == `SSE_CB_SET) begin
        res = val | (8'h01 << op[5:3]);
        hit = 1'b1;
      end else if (op[7:6] == `SSE_CB_SHIFT &&
                   (op[5:3] == `SSE_SH_LEFT || op[5:3] == `SSE_SH_RIGHT)) begin
        hit = 1'b1;
        if (op[5:3] == `SSE_SH_LEFT) begin
          res = {val[6:0], 1'b0};
          nf[`SSE_F_C] = val[7];
        end else begin
          res = {val[7], val[7:1]};
          nf[`SSE_F_C] = val[0];
        end
        nf[`SSE_F_S]  = res[7];
        nf[`SSE_F_Z]  = (res == 8'h00);
        nf[`SSE_F_H]  = 1'b0;
        nf[`SSE_F_PV] = ~^res;
        nf[`SSE_F_N]  = 1'b0;
      end
      cb_result = {hit, nf, res};
    end
  endfunction

  // ----------------------------------------------------------------
  // 16-bit subtract with borrow datapath
  // ----------------------------------------------------------------
  wire [15:0] sub_src = pair_val(instr_byte[5:4],
                                 {gpr[`SSE_CODE_B], gpr[`SSE_CODE_C]},
                                 {gpr[`SSE_CODE_D], gpr[`SSE_CODE_E]}, ptr_val, stk_reg);
  wire [16:0] sub_full = {1'b0, ptr_val} - {1'b0, sub_src}
                         - {16'h0000, flags[`SSE_F_C]};
  wire [12:0] sub_low = {1'b0, ptr_val[11:0]} - {1'b0, sub_src[11:0]}
                        - {12'h000, flags[`SSE_F_C]};
  wire        sub_ovf = (ptr_val[15] != sub_src[15]) &&
                        (sub_full[15] != ptr_val[15]);
  wire [7:0]  sub_flags = {sub_full[15], (sub_full[15:0] == 16'h0000), 1'b0,
                           sub_low[12], 1'b0, sub_ovf, 1'b1, sub_full[16]};

  // register-form bit operation, evaluated straight off the incoming byte
  wire [16:0] reg_cb = cb_result(instr_byte, gpr[instr_byte[2:0]], flags);
  // memory-form bit operation on the returned byte
  wire [16:0] mem_cb = cb_result(op_byte, mem_rdata, flags);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // memory forms cost two extra cycles; byte intake pauses meanwhile
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (take) begin
          if (instr_byte == `SSE_PFX_ED)
            next_state = S_ED;
          else if (instr_byte == `SSE_PFX_CB)
            next_state = S_CB;
          else if (instr_byte == `SSE_PFX_XIDX || instr_byte == `SSE_PFX_YIDX)
            next_state = S_IXP;
        end
      end
      S_ED: begin
        if (take)
          next_state = S_IDLE;
      end
      S_CB: begin
        if (take)
          next_state = (instr_byte[2:0] == `SSE_CODE_MEM) ? S_MRD : S_IDLE;
      end
      S_IXP: begin
        if (take)
          next_state = (instr_byte == `SSE_PFX_CB) ? S_DISP : S_IDLE;
      end
      S_DISP: begin
        if (take)
          next_state = S_XOP;
      end
      S_XOP: begin
        if (take)
          next_state = S_MRD;
      end
      S_MRD: next_state = S_MWB;
      S_MWB: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // datapath, register file and register bus
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clk) begin
    if (reset) begin
      state       <= S_IDLE;
      instr_ready <= 1'b0;
      mem_rd      <= 1'b0;
      mem_wr      <= 1'b0;
      mem_addr    <= `SSE_RST_WORD;
      mem_wdata   <= `SSE_RST_BYTE;
      op_done     <= 1'b0;
      bus_rdata   <= `SSE_RST_WORD;
      stk_reg     <= `SSE_RST_WORD;
      xidx_reg    <= `SSE_RST_WORD;
      yidx_reg    <= `SSE_RST_WORD;
      use_yidx    <= 1'b0;
      disp        <= `SSE_RST_BYTE;
      op_byte     <= `SSE_RST_BYTE;
      for (i = 0; i < 8; i = i + 1)
        gpr[i] <= `SSE_RST_BYTE;
    end else begin
      state       <= next_state;
      instr_ready <= (next_state != S_MRD) && (next_state != S_MWB);
      mem_rd      <= 1'b0;
      mem_wr      <= 1'b0;
      op_done     <= 1'b0;
      case (state)
        S_IDLE: begin
          if (take && instr_byte == `SSE_OP_SETC) begin
            gpr[`SSE_CODE_F] <= (flags & ~((8'h01 << `SSE_F_H) | (8'h01 << `SSE_F_N)))
                                | (8'h01 << `SSE_F_C);
            op_done <= 1'b1;
          end
          if (take)
            use_yidx <= (instr_byte == `SSE_PFX_YIDX);
        end
        S_ED: begin
          if (take && instr_byte[7:6] == `SSE_ED_GRP &&
              instr_byte[3:0] == `SSE_ED_SUBW) begin
            gpr[`SSE_CODE_H] <= sub_full[15:8];
            gpr[`SSE_CODE_L] <= sub_full[7:0];
            gpr[`SSE_CODE_F] <= sub_flags;
            op_done <= 1'b1;
          end
        end
        S_CB: begin
          if (take) begin
            if (instr_byte[2:0] == `SSE_CODE_MEM) begin
              op_byte  <= instr_byte;
              mem_addr <= ptr_val;
              mem_rd   <= 1'b1;
            end else if (reg_cb[16]) begin
              gpr[instr_byte[2:0]] <= reg_cb[7:0];
              gpr[`SSE_CODE_F]     <= reg_cb[15:8];
              op_done <= 1'b1;
            end
          end
        end
        S_DISP: begin
          if (take)
            disp <= instr_byte;
        end
        S_XOP: begin
          if (take) begin
            op_byte  <= instr_byte;
            mem_addr <= idx_val + {{8{disp[7]}}, disp};
            mem_rd   <= 1'b1;
          end
        end
        S_MWB: begin
          // unknown bit operations still read memory but write nothing back
          if (mem_cb[16]) begin
            mem_wdata        <= mem_cb[7:0];
            mem_wr           <= 1'b1;
            gpr[`SSE_CODE_F] <= mem_cb[15:8];
            op_done          <= 1'b1;
          end
        end
        default: begin
        end
      endcase
      // software writes land last, so they win over a same-cycle result
      if (bus_wr) begin
        case (bus_addr)
          `SSE_REG_FIRST: begin
            gpr[`SSE_CODE_B] <= bus_wdata[15:8];
            gpr[`SSE_CODE_C] <= bus_wdata[7:0];
          end
          `SSE_REG_SECOND: begin
            gpr[`SSE_CODE_D] <= bus_wdata[15:8];
            gpr[`SSE_CODE_E] <= bus_wdata[7:0];
          end
          `SSE_REG_PTR: begin
            gpr[`SSE_CODE_H] <= bus_wdata[15:8];
            gpr[`SSE_CODE_L] <= bus_wdata[7:0];
          end
          `SSE_REG_STK:  stk_reg  <= bus_wdata;
          `SSE_REG_XIDX: xidx_reg <= bus_wdata;
          `SSE_REG_YIDX: yidx_reg <= bus_wdata;
          `SSE_REG_AF: begin
            gpr[`SSE_CODE_A] <= bus_wdata[15:8];
            gpr[`SSE_CODE_F] <= bus_wdata[7:0];
          end
          default: begin
          end
        endcase
      end
      // read data stand only in the cycle after the strobe
      if (bus_rd) begin
        case (bus_addr)
          `SSE_REG_FIRST:  bus_rdata <= {gpr[`SSE_CODE_B], gpr[`SSE_CODE_C]};
          `SSE_REG_SECOND: bus_rdata <= {gpr[`SSE_CODE_D], gpr[`SSE_CODE_E]};
          `SSE_REG_PTR:    bus_rdata <= ptr_val;
          `SSE_REG_STK:    bus_rdata <= stk_reg;
          `SSE_REG_XIDX:   bus_rdata <= xidx_reg;
          `SSE_REG_YIDX:   bus_rdata <= yidx_reg;
          `SSE_REG_AF:     bus_rdata <= {gpr[`SSE_CODE_A], flags};
          `SSE_REG_STATUS: bus_rdata <= {15'h0000, (state != S_IDLE)};
          default:         bus_rdata <= `SSE_RST_WORD;
        endcase
      end else begin
        bus_rdata <= `SSE_RST_WORD;
      end
    end
  end

endmodule

// ---- src/sse_map.vh ----
`ifndef SSE_MAP_VH
`define SSE_MAP_VH

// register bus word offsets (4-bit address, 16-bit data)
`define SSE_REG_FIRST   4'h0
`define SSE_REG_SECOND  4'h1
`define SSE_REG_PTR     4'h2
`define SSE_REG_STK     4'h3
`define SSE_REG_XIDX    4'h4
`define SSE_REG_YIDX    4'h5
`define SSE_REG_AF      4'h6
`define SSE_REG_STATUS  4'h7

// reset values
`define SSE_RST_BYTE    8'h00
`define SSE_RST_WORD    16'h0000

// flag bit positions in the flag byte
`define SSE_F_S         7
`define SSE_F_Z         6
`define SSE_F_H         4
`define SSE_F_PV        2
`define SSE_F_N         1
`define SSE_F_C         0

// opcode bytes and fields
`define SSE_OP_SETC     8'h37
`define SSE_PFX_ED      8'hED
`define SSE_PFX_CB      8'hCB
`define SSE_PFX_XIDX    8'hDD
`define SSE_PFX_YIDX    8'hFD
`define SSE_ED_GRP      2'h1
`define SSE_ED_SUBW     4'h2
`define SSE_CB_SET      2'h3
`define SSE_CB_SHIFT    2'h0
`define SSE_SH_LEFT     3'h4
`define SSE_SH_RIGHT    3'h5
`define SSE_CODE_B      3'h0
`define SSE_CODE_C      3'h1
`define SSE_CODE_D      3'h2
`define SSE_CODE_E      3'h3
`define SSE_CODE_H      3'h4
`define SSE_CODE_L      3'h5
`define SSE_CODE_MEM    3'h6
`define SSE_CODE_F      3'h6
`define SSE_CODE_A      3'h7
`define SSE_PAIR_FIRST  2'h0
`define SSE_PAIR_SECOND 2'h1
`define SSE_PAIR_PTR    2'h2
`define SSE_PAIR_STK    2'h3

`endif
